//--- ptc_cfg.svh
`ifndef PTC_CFG_SVH
`define PTC_CFG_SVH
// ==========================================================
// Object indices
`define PTC_IDX_FAULT      16'h603F
`define PTC_IDX_CMD        16'h6040
`define PTC_IDX_STATE      16'h6041
`define PTC_IDX_MODE_SEL   16'h6060
`define PTC_IDX_MODE_SHOWN 16'h6061
`define PTC_IDX_SETPOINT   16'h6071
`define PTC_IDX_TQ_CEIL    16'h6072
`define PTC_IDX_CUR_CEIL   16'h6073
`define PTC_IDX_TQ_OUT     16'h6074
`define PTC_IDX_NP_CUR     16'h6075
`define PTC_IDX_NP_TQ      16'h6076
`define PTC_IDX_TQ_MEAS    16'h6077
`define PTC_IDX_CUR_MEAS   16'h6078
`define PTC_IDX_VBUS       16'h6079
`define PTC_IDX_RAMP_RATE  16'h6087
`define PTC_IDX_RAMP_SHAPE 16'h6088
`define PTC_IDX_LIM_FWD    16'h60E0
`define PTC_IDX_LIM_REV    16'h60E1
// ==========================================================
// Field positions and codes
`define PTC_CW_HALT        8
`define PTC_CW_FRESET      7
`define PTC_SW_REACHED     10
`define PTC_MODE_TORQUE    8'h04
`define PTC_MODE_NONE      8'h00
`define PTC_SHAPE_STEP     16'hFFFF
`define PTC_SHAPE_LINEAR   16'h0000
`define PTC_AB_NONE        32'h0000_0000
`define PTC_AB_TOO_HIGH    32'h0609_0031
`define PTC_AB_RANGE       32'h0604_0030
`define PTC_AB_NO_DATA     32'h0800_0024
`define PTC_AB_NO_OBJ      32'h0602_0000
`define PTC_AB_READ_ONLY   32'h0601_0002
`define PTC_FAULT_EXT      16'hFF00
// ==========================================================
// Reset values and timing
`define PTC_RST_CUR_CEIL   16'h0BB8
`define PTC_RST_LIMIT      16'h03E8
`define PTC_RST_RATE       32'h0000_03E8
`define PTC_RST_NP_CUR     32'h0000_30D4
`define PTC_CLK_HZ         33'h0_0262_5A00
`endif

//--- ptc_pkg.sv
package ptc_pkg;
   // Gray path: disabled, ready, switched on, enabled
   typedef enum logic [2:0] {
      PTC_DISABLED = 3'b000,
      PTC_READY    = 3'b001,
      PTC_SW_ON    = 3'b011,
      PTC_ENABLED  = 3'b010,
      PTC_QSTOP    = 3'b110,
      PTC_FAULT    = 3'b111
   } ptc_state_e;
   typedef logic signed [15:0] ptc_torque_t;
endpackage

//--- ptc_od_if.sv
`timescale 1ns/1ps
interface ptc_od_if;
   logic        req;
   logic        write;
   logic [15:0] index;
   logic [31:0] wdata;
   logic        ack;
   logic [31:0] rdata;
   logic [31:0] abort;
   modport drive  (input req, write, index, wdata,
                   output ack, rdata, abort);
   modport master (output req, write, index, wdata,
                   input ack, rdata, abort);
endinterface

//--- ptc_drive.sv
`timescale 1ns/1ps
`include "ptc_cfg.svh"
// Overview of operation
// - Mode value 4 selects torque profile
// - Mode display follows only accepted modes
// - Torque runs only in operation enabled
// - Zero set-point gives zero torque
// - Halt bit 8 stops, clear continues
// - Detected error stops, enters fault state
// - Disable or quick stop ends motion
// - Safe torque removal input stops torque
// - Halt clear: bit 10 means reached
// - Halt set: bit 10 means velocity zero
// - Dynamic brake inactive in torque mode
// - Starting operation zeroes internal target
// - New set-point applies at once
// - Separate forward and reverse torque limits
// - Linear ramp follows configured slope up to one unit per cycle
// - Status cleared on mode, disable, stop
// - Report instant and filtered motor current; code reports only the instant value
// - Set-point signed per-thousand current command
// - Rated current set before any target
// - Too high set-point aborted 0x06090031
module ptc_drive
(
   input  wire logic                sys_clk_i,
   input  wire logic                rst_b_i,
   input  wire logic                ce_i,
   ptc_od_if.drive                  od,
   input  wire logic                fault_i,
   input  wire logic                safe_torque_removal_input_i,
   input  wire logic                velocity_zero_i,
   input  wire logic                brake_cfg_i,
   input  wire logic signed [15:0]  torque_meas_i,
   input  wire logic signed [15:0]  current_meas_i,
   input  wire logic        [31:0]  vbus_meas_i,
   output logic signed      [15:0]  torque_producing_current_o,
   output logic                     dyn_brake_en_o
);
   // =======================================================
   // Helpers
   function automatic logic [15:0] mag(input logic [15:0] v);
      mag = v[15] ? 16'(-v) : v;
   endfunction

   function automatic ptc_pkg::ptc_torque_t clamp(
      input ptc_pkg::ptc_torque_t d,
      input logic [15:0] fwd,
      input logic [15:0] rev);
      logic signed [16:0] hi;
      logic signed [16:0] lo;
      hi = $signed({1'b0, fwd});
      lo = -$signed({1'b0, rev});
      // Sign-extend as signed, or negative demands compare as huge values
      if ($signed({d[15], d}) > hi)
         clamp = 16'(hi);
      else if ($signed({d[15], d}) < lo)
         clamp = 16'(lo);
      else
         clamp = d;
   endfunction

   // =======================================================
   // Registers
   logic [15:0]         fault_reason;
   logic [15:0]         drive_command_word;
   logic [7:0]          operating_mode_select;
   logic [7:0]          operating_mode_shown;
   ptc_pkg::ptc_torque_t torque_setpoint;
   logic [15:0]         torque_ceiling;
   logic [15:0]         current_ceiling;
   ptc_pkg::ptc_torque_t torque_command_out;
   logic [31:0]         nameplate_current;
   logic [31:0]         nameplate_torque;
   logic [15:0]         torque_measured;
   logic [15:0]         current_measured;
   logic [31:0]         bus_voltage_measured;
   logic [31:0]         torque_ramp_rate;
   logic [15:0]         torque_ramp_shape;
   logic [15:0]         torque_limit_forward;
   logic [15:0]         torque_limit_reverse;
   logic                reached;
   ptc_pkg::ptc_state_e state;
   ptc_pkg::ptc_state_e next_state;
   logic                sto_meta;
   logic                sto_sync;
   logic                freset_d;
   logic [32:0]         ramp_acc;

   // =======================================================
   // Object access decode
   logic        take;
   logic        wr_ok;
   logic [31:0] next_abort;
   logic [31:0] next_rdata;
   assign take  = ce_i && od.req && !od.ack;
   assign wr_ok = take && od.write && (next_abort == `PTC_AB_NONE);

   always_comb
   begin
      next_abort = `PTC_AB_NONE;
      next_rdata = 32'h0000_0000;
      case (od.index)
         `PTC_IDX_FAULT:      next_rdata = {16'h0000, fault_reason};
         `PTC_IDX_CMD:        next_rdata = {16'h0000, drive_command_word};
         `PTC_IDX_STATE:
         begin
            next_rdata[3:0] = {state == ptc_pkg::PTC_FAULT,
                               state == ptc_pkg::PTC_ENABLED,
                               state == ptc_pkg::PTC_SW_ON ||
                               state == ptc_pkg::PTC_ENABLED,
                               state != ptc_pkg::PTC_DISABLED &&
                               state != ptc_pkg::PTC_FAULT};
            next_rdata[5] = state != ptc_pkg::PTC_QSTOP;
            next_rdata[6] = state == ptc_pkg::PTC_DISABLED;
            next_rdata[`PTC_SW_REACHED] = reached;
         end
         `PTC_IDX_MODE_SEL:   next_rdata = {24'h00_0000, operating_mode_select};
         `PTC_IDX_MODE_SHOWN: next_rdata = {24'h00_0000, operating_mode_shown};
         `PTC_IDX_SETPOINT:   next_rdata = {{16{torque_setpoint[15]}},
                                            torque_setpoint};
         `PTC_IDX_TQ_CEIL:    next_rdata = {16'h0000, torque_ceiling};
         `PTC_IDX_CUR_CEIL:   next_rdata = {16'h0000, current_ceiling};
         `PTC_IDX_TQ_OUT:     next_rdata = {{16{torque_command_out[15]}},
                                            torque_command_out};
         `PTC_IDX_NP_CUR:     next_rdata = nameplate_current;
         `PTC_IDX_NP_TQ:      next_rdata = nameplate_torque;
         `PTC_IDX_TQ_MEAS:    next_rdata = {{16{torque_measured[15]}},
                                            torque_measured};
         `PTC_IDX_CUR_MEAS:   next_rdata = {{16{current_measured[15]}},
                                            current_measured};
         `PTC_IDX_VBUS:       next_rdata = bus_voltage_measured;
         `PTC_IDX_RAMP_RATE:  next_rdata = torque_ramp_rate;
         `PTC_IDX_RAMP_SHAPE: next_rdata = {{16{torque_ramp_shape[15]}},
                                            torque_ramp_shape};
         `PTC_IDX_LIM_FWD:    next_rdata = {16'h0000, torque_limit_forward};
         `PTC_IDX_LIM_REV:    next_rdata = {16'h0000, torque_limit_reverse};
         default:             next_abort = `PTC_AB_NO_OBJ;
      endcase
      if (od.write && next_abort == `PTC_AB_NONE)
      begin
         case (od.index)
            `PTC_IDX_FAULT, `PTC_IDX_STATE, `PTC_IDX_MODE_SHOWN,
            `PTC_IDX_TQ_OUT, `PTC_IDX_TQ_MEAS, `PTC_IDX_CUR_MEAS,
            `PTC_IDX_VBUS:
               next_abort = `PTC_AB_READ_ONLY;
            `PTC_IDX_MODE_SEL:
               if (od.wdata[7:0] != `PTC_MODE_TORQUE &&
                   od.wdata[7:0] != `PTC_MODE_NONE)
                  next_abort = `PTC_AB_RANGE;
            `PTC_IDX_SETPOINT:
               if (mag(od.wdata[15:0]) > current_ceiling)
                  next_abort = `PTC_AB_TOO_HIGH;
            `PTC_IDX_RAMP_SHAPE:
               if (od.wdata[15:0] != `PTC_SHAPE_STEP &&
                   od.wdata[15:0] != `PTC_SHAPE_LINEAR)
                  next_abort = `PTC_AB_NO_DATA;
            `PTC_IDX_RAMP_RATE, `PTC_IDX_NP_CUR:
               if (od.wdata == 32'h0000_0000 || od.wdata[31])
                  next_abort = `PTC_AB_RANGE;
            default:
               next_abort = `PTC_AB_NONE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         od.ack   <= 1'b0;
         od.rdata <= 32'h0000_0000;
         od.abort <= `PTC_AB_NONE;
      end
      else if (ce_i)
      begin
         od.ack <= take;
         if (take)
         begin
            od.rdata <= od.write ? 32'h0000_0000 : next_rdata;
            od.abort <= next_abort;
         end
      end
   end

   // =======================================================
   // Configuration objects
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         drive_command_word    <= 16'h0000;
         operating_mode_select <= `PTC_MODE_NONE;
         torque_ceiling        <= `PTC_RST_LIMIT;
         current_ceiling       <= `PTC_RST_CUR_CEIL;
         nameplate_current     <= `PTC_RST_NP_CUR;
         nameplate_torque      <= 32'h0000_0000;
         torque_ramp_rate      <= `PTC_RST_RATE;
         torque_ramp_shape     <= `PTC_SHAPE_LINEAR;
         torque_limit_forward  <= `PTC_RST_LIMIT;
         torque_limit_reverse  <= `PTC_RST_LIMIT;
      end
      else if (wr_ok)
      begin
         case (od.index)
            `PTC_IDX_CMD:        drive_command_word    <= od.wdata[15:0];
            `PTC_IDX_MODE_SEL:   operating_mode_select <= od.wdata[7:0];
            `PTC_IDX_TQ_CEIL:    torque_ceiling        <= od.wdata[15:0];
            `PTC_IDX_CUR_CEIL:   current_ceiling       <= od.wdata[15:0];
            `PTC_IDX_NP_CUR:     nameplate_current     <= od.wdata;
            `PTC_IDX_NP_TQ:      nameplate_torque      <= od.wdata;
            `PTC_IDX_RAMP_RATE:  torque_ramp_rate      <= od.wdata;
            `PTC_IDX_RAMP_SHAPE: torque_ramp_shape     <= od.wdata[15:0];
            `PTC_IDX_LIM_FWD:    torque_limit_forward  <= od.wdata[15:0];
            `PTC_IDX_LIM_REV:    torque_limit_reverse  <= od.wdata[15:0];
            default:             torque_ramp_shape     <= torque_ramp_shape;
         endcase
      end
   end

   // =======================================================
   // Drive state machine
   logic stop_any;
   assign stop_any = state != ptc_pkg::PTC_ENABLED;

   always_comb
   begin
      next_state = state;
      case (state)
         ptc_pkg::PTC_DISABLED:
            if (drive_command_word[2:0] == 3'b110)
               next_state = ptc_pkg::PTC_READY;
         ptc_pkg::PTC_READY:
            if (!drive_command_word[1])
               next_state = ptc_pkg::PTC_DISABLED;
            else if (drive_command_word[2:0] == 3'b111)
               next_state = ptc_pkg::PTC_SW_ON;
         ptc_pkg::PTC_SW_ON:
            if (!drive_command_word[1] || !drive_command_word[2])
               next_state = ptc_pkg::PTC_DISABLED;
            else if (drive_command_word[3])
               next_state = ptc_pkg::PTC_ENABLED;
         ptc_pkg::PTC_ENABLED:
            if (!drive_command_word[1])
               next_state = ptc_pkg::PTC_DISABLED;
            else if (!drive_command_word[2])
               next_state = ptc_pkg::PTC_QSTOP;
            else if (!drive_command_word[3])
               next_state = ptc_pkg::PTC_SW_ON;
         ptc_pkg::PTC_QSTOP:
            if (!drive_command_word[1])
               next_state = ptc_pkg::PTC_DISABLED;
         ptc_pkg::PTC_FAULT:
            if (drive_command_word[`PTC_CW_FRESET] && !freset_d && !fault_i)
               next_state = ptc_pkg::PTC_DISABLED;
         default:
            next_state = ptc_pkg::PTC_FAULT;
      endcase
      if (fault_i)
         next_state = ptc_pkg::PTC_FAULT;
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state        <= ptc_pkg::PTC_DISABLED;
         freset_d     <= 1'b0;
         fault_reason <= 16'h0000;
      end
      else if (ce_i)
      begin
         state    <= next_state;
         freset_d <= drive_command_word[`PTC_CW_FRESET];
         if (fault_i)
            fault_reason <= `PTC_FAULT_EXT;
         else if (next_state == ptc_pkg::PTC_DISABLED &&
                  state == ptc_pkg::PTC_FAULT)
            fault_reason <= 16'h0000;
      end
   end

   // =======================================================
   // Pin sync and measurements
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         sto_meta             <= 1'b0;
         sto_sync             <= 1'b0;
         torque_measured      <= 16'h0000;
         current_measured     <= 16'h0000;
         bus_voltage_measured <= 32'h0000_0000;
      end
      else if (ce_i)
      begin
         sto_meta             <= safe_torque_removal_input_i;
         sto_sync             <= sto_meta;
         torque_measured      <= torque_meas_i;
         current_measured     <= current_meas_i;
         bus_voltage_measured <= vbus_meas_i;
      end
   end

   // =======================================================
   // Mode acceptance and set-point
   logic mode_change;
   logic go_enabled;
   assign mode_change = operating_mode_shown != operating_mode_select;
   assign go_enabled  = next_state == ptc_pkg::PTC_ENABLED &&
                        state != ptc_pkg::PTC_ENABLED;

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         operating_mode_shown <= `PTC_MODE_NONE;
         torque_setpoint      <= 16'h0000;
      end
      else if (ce_i)
      begin
         operating_mode_shown <= operating_mode_select;
         if (go_enabled)
            torque_setpoint <= 16'h0000;
         else if (wr_ok && od.index == `PTC_IDX_SETPOINT)
            torque_setpoint <= od.wdata[15:0];
      end
   end

   // =======================================================
   // Torque profile generator
   logic                 run;
   logic                 halt;
   ptc_pkg::ptc_torque_t goal;
   logic [32:0]          acc_sum;
   assign run  = !stop_any && !sto_sync &&
                 operating_mode_shown == `PTC_MODE_TORQUE && !mode_change;
   assign halt = drive_command_word[`PTC_CW_HALT];
   assign goal = (run && !halt) ? torque_setpoint : 16'sh0000;
   assign acc_sum = ramp_acc + {1'b0, torque_ramp_rate};

   // Ramp step capped at one unit per cycle to keep the adder narrow
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         torque_command_out <= 16'h0000;
         ramp_acc           <= 33'h0_0000_0000;
      end
      else if (ce_i)
      begin
         if (!run)
         begin
            torque_command_out <= 16'h0000;
            ramp_acc           <= 33'h0_0000_0000;
         end
         else if (torque_ramp_shape == `PTC_SHAPE_STEP ||
                  torque_command_out == goal)
         begin
            torque_command_out <= goal;
            ramp_acc           <= 33'h0_0000_0000;
         end
         else if (acc_sum >= `PTC_CLK_HZ)
         begin
            ramp_acc <= acc_sum - `PTC_CLK_HZ;
            torque_command_out <= (goal > torque_command_out) ?
               16'(torque_command_out + 16'sh0001) :
               16'(torque_command_out - 16'sh0001);
         end
         else
            ramp_acc <= acc_sum;
      end
   end

   // =======================================================
   // Outputs and target reached
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         torque_producing_current_o <= 16'h0000;
         dyn_brake_en_o             <= 1'b0;
         reached                    <= 1'b0;
      end
      else if (ce_i)
      begin
         torque_producing_current_o <= clamp(torque_command_out,
                                             torque_limit_forward,
                                             torque_limit_reverse);
         dyn_brake_en_o <= brake_cfg_i &&
                           operating_mode_shown != `PTC_MODE_TORQUE;
         if (mode_change || stop_any)
            reached <= 1'b0;
         else if (halt)
            reached <= velocity_zero_i;
         else
            reached <= torque_command_out == goal;
      end
   end
endmodule // ptc_drive

//--- ptc_master.sv
`timescale 1ns/1ps
`include "ptc_cfg.svh"
module ptc_master
(
   input  wire logic        sys_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        ce_i,
   ptc_od_if.master         od,
   input  wire logic        cmd_valid_i,
   input  wire logic        cmd_write_i,
   input  wire logic [15:0] cmd_index_i,
   input  wire logic [31:0] cmd_wdata_i,
   output logic             cmd_ready_o,
   output logic             done_o,
   output logic [31:0]      rdata_o,
   output logic [31:0]      abort_o
);
   // ==========================================================
   // One object access in flight; the user must respect ready
   // Mode, command, slope, rated current and set-point
   // Host orders writes as issued by the user
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         od.req      <= 1'b0;
         od.write    <= 1'b0;
         od.index    <= 16'h0000;
         od.wdata    <= 32'h0000_0000;
         cmd_ready_o <= 1'b1;
         done_o      <= 1'b0;
         rdata_o     <= 32'h0000_0000;
         abort_o     <= `PTC_AB_NONE;
      end
      else if (ce_i)
      begin
         done_o <= 1'b0;
         if (cmd_ready_o && cmd_valid_i)
         begin
            od.req      <= 1'b1;
            od.write    <= cmd_write_i;
            od.index    <= cmd_index_i;
            od.wdata    <= cmd_wdata_i;
            cmd_ready_o <= 1'b0;
         end
         else if (od.req && od.ack)
         begin
            od.req      <= 1'b0;
            cmd_ready_o <= 1'b1;
            done_o      <= 1'b1;
            rdata_o     <= od.rdata;
            abort_o     <= od.abort;
         end
      end
   end
endmodule // ptc_master

//--- ptc_properties.sv
`timescale 1ns/1ps
`include "ptc_cfg.svh"
module ptc_properties
(
   input  wire logic        sys_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        req,
   input  wire logic        write,
   input  wire logic [15:0] index,
   input  wire logic [31:0] wdata,
   input  wire logic        ack,
   input  wire logic [31:0] rdata,
   input  wire logic [31:0] abort
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   // ==========================================================
   // Object bus answers
   ack_one_cycle_a: assert property (
      ack |=> !ack) else $error("ack longer than one cycle");
   ack_next_edge_a: assert property (
      $rose(req) |=> ack) else $error("ack not one cycle after req");
   ack_has_req_a: assert property (
      ack |-> $past(req)) else $error("ack without request");
   req_held_a: assert property (
      req && !ack |=> req && $stable(index) && $stable(wdata)
      && $stable(write)) else $error("request changed before ack");
   req_drop_a: assert property (
      ack |=> !req) else $error("req not dropped after ack");
   write_zero_a: assert property (
      ack && write |-> rdata == 32'h0000_0000) else $error("rdata on write");
   // ==========================================================
   // Refusal codes
   status_ro_a: assert property (
      ack && write && index == `PTC_IDX_STATE
      |-> abort == `PTC_AB_READ_ONLY) else $error("status write taken");
   mode_range_a: assert property (
      ack && write && index == `PTC_IDX_MODE_SEL && wdata[7:0] != 8'h00
      && wdata[7:0] != 8'h04 |-> abort == `PTC_AB_RANGE)
      else $error("bad mode taken");
   shape_code_a: assert property (
      ack && write && index == `PTC_IDX_RAMP_SHAPE && wdata[15:0] != 16'h0000
      && wdata[15:0] != 16'hFFFF |-> abort == `PTC_AB_NO_DATA)
      else $error("bad shape taken");
   wr_ok_c: cover property (ack && write && abort == 32'h0000_0000);
   wr_bad_c: cover property (ack && write && abort != 32'h0000_0000);
   rd_c: cover property (ack && !write);
endmodule // ptc_properties

//--- profile_torque_mode_control_tb.sv
`timescale 1ns/1ps
`include "ptc_cfg.svh"
module profile_torque_mode_control_tb;
   logic               clk, rst_b, vld, wr, flt, safe_torque_removal_input, vz, brk, rdy, done;
   logic        [15:0] idx;
   logic        [31:0] wd, rd_o, ab_o, rv;
   logic signed [15:0] tq, cm;
   wire  logic         brk_o;
   wire  logic  [15:0] iq;
   int                 miscompares, comparisons;
   ptc_od_if od_if();
   ptc_drive ptc_drive_inst(.sys_clk_i(clk), .rst_b_i(rst_b), .ce_i(1'b1),
      .od(od_if), .fault_i(flt), .safe_torque_removal_input_i(safe_torque_removal_input),
      .velocity_zero_i(vz), .brake_cfg_i(brk), .torque_meas_i(tq),
      .current_meas_i(cm), .vbus_meas_i(32'h0000_0190),
      .torque_producing_current_o(iq), .dyn_brake_en_o(brk_o));
   ptc_master ptc_master_inst(.sys_clk_i(clk), .rst_b_i(rst_b), .ce_i(1'b1),
      .od(od_if), .cmd_valid_i(vld), .cmd_write_i(wr), .cmd_index_i(idx),
      .cmd_wdata_i(wd), .cmd_ready_o(rdy), .done_o(done), .rdata_o(rd_o),
      .abort_o(ab_o));
   ptc_properties ptc_properties_inst(.sys_clk_i(clk), .rst_b_i(rst_b),
      .req(od_if.req), .write(od_if.write), .index(od_if.index),
      .wdata(od_if.wdata), .ack(od_if.ack), .rdata(od_if.rdata),
      .abort(od_if.abort));
   initial
   begin
      clk = 0;
      forever #12.5 clk = ~clk;
   end
   // ==========================================================
   // Access and compare tasks
   task complete_run;
      $display("counts: %0d compared, %0d mismatched", comparisons,
         miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task miss(input string m);
      $display("mismatch at %0t: %s", $time, m);
      miscompares++;
   endtask
   task chk32(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) miss($sformatf("word %h expected %h", g, e));
   endtask
   // Answer waits are bounded so a dead bus ends the run
   task xfer(input logic w, input logic [15:0] i, input logic [31:0] d,
             input logic [31:0] ea);
      int n;
      @(negedge clk);
      vld = 1; wr = w; idx = i; wd = d;
      for (n = 0; rdy !== 1'b1 && n < 50; n++) @(negedge clk);
      if (rdy !== 1'b1) miss("never ready");
      @(negedge clk);
      vld = 0;
      for (n = 0; done !== 1'b1 && n < 50; n++) @(negedge clk);
      if (done !== 1'b1)
      begin
         miss("no answer");
         complete_run;
      end
      rv = rd_o;
      chk32(ab_o, ea);
   endtask
   task rdv(input logic [15:0] i, input logic [31:0] m, input logic [31:0] e);
      xfer(1'b0, i, 32'h0000_0000, `PTC_AB_NONE);
      chk32(rv & m, e);
   endtask
   task wt(input logic [15:0] e);
      int n;
      for (n = 0; iq !== e && n < 60; n++) @(negedge clk);
      comparisons++;
      if (iq !== e) miss($sformatf("torque %h expected %h", iq, e));
   endtask
   task note(input string s);
      $display("test %s finished", s);
   endtask
   // ==========================================================
   // Sequence
   initial
   begin
      rst_b = 0; vld = 0; wr = 0; idx = 0; wd = 0; flt = 0; safe_torque_removal_input = 0;
      vz = 0; brk = 0; tq = -16'sd5; cm = 16'sd7;
      miscompares = 0; comparisons = 0;
      repeat (2) @(negedge clk);
      rst_b = 1;
      rdv(`PTC_IDX_LIM_FWD, '1, 32'h0000_03E8);
      rdv(`PTC_IDX_CUR_CEIL, '1, 32'h0000_0BB8);
      rdv(`PTC_IDX_NP_CUR, '1, 32'h0000_30D4);
      rdv(`PTC_IDX_RAMP_SHAPE, '1, 32'h0000_0000);
      note("reset values");
      xfer(1, 16'h6000, 0, `PTC_AB_NO_OBJ);
      xfer(1, `PTC_IDX_STATE, 0, `PTC_AB_READ_ONLY);
      xfer(1, `PTC_IDX_MODE_SEL, 3, `PTC_AB_RANGE);
      rdv(`PTC_IDX_MODE_SHOWN, '1, 32'h0000_0000);
      xfer(1, `PTC_IDX_RAMP_SHAPE, 1, `PTC_AB_NO_DATA);
      xfer(1, `PTC_IDX_RAMP_RATE, 0, `PTC_AB_RANGE);
      xfer(1, `PTC_IDX_NP_CUR, 0, `PTC_AB_RANGE);
      note("refusals");
      xfer(1, `PTC_IDX_MODE_SEL, 4, `PTC_AB_NONE);
      rdv(`PTC_IDX_MODE_SHOWN, '1, 32'h0000_0004);
      xfer(1, `PTC_IDX_RAMP_SHAPE, 32'h0000_FFFF, `PTC_AB_NONE);
      xfer(1, `PTC_IDX_CMD, 32'h0000_0006, `PTC_AB_NONE);
      xfer(1, `PTC_IDX_CMD, 32'h0000_0007, `PTC_AB_NONE);
      xfer(1, `PTC_IDX_CMD, 32'h0000_000F, `PTC_AB_NONE);
      rdv(`PTC_IDX_STATE, 32'h0000_0004, 32'h0000_0004);
      rdv(`PTC_IDX_SETPOINT, '1, 32'h0000_0000);
      xfer(1, `PTC_IDX_SETPOINT, 300, `PTC_AB_NONE);
      wt(16'h012C);
      rdv(`PTC_IDX_STATE, 32'h0000_0400, 32'h0000_0400);
      note("enable");
      xfer(1, `PTC_IDX_LIM_FWD, 200, `PTC_AB_NONE);
      wt(16'h00C8);
      xfer(1, `PTC_IDX_LIM_REV, 100, `PTC_AB_NONE);
      xfer(1, `PTC_IDX_SETPOINT, 32'hFFFF_FED4, `PTC_AB_NONE);
      wt(16'hFF9C);
      rdv(`PTC_IDX_TQ_OUT, '1, 32'hFFFF_FED4);
      xfer(1, `PTC_IDX_SETPOINT, 32'h0000_0BB9, `PTC_AB_TOO_HIGH);
      rdv(`PTC_IDX_SETPOINT, '1, 32'hFFFF_FED4);
      xfer(1, `PTC_IDX_SETPOINT, 32'h0000_0BB8, `PTC_AB_NONE);
      wt(16'h00C8);
      note("limits");
      xfer(1, `PTC_IDX_CMD, 32'h0000_010F, `PTC_AB_NONE);
      wt(16'h0000);
      rdv(`PTC_IDX_STATE, 32'h0000_0400, 32'h0000_0000);
      vz = 1;
      rdv(`PTC_IDX_STATE, 32'h0000_0400, 32'h0000_0400);
      vz = 0;
      xfer(1, `PTC_IDX_CMD, 32'h0000_000F, `PTC_AB_NONE);
      wt(16'h00C8);
      safe_torque_removal_input = 1;
      wt(16'h0000);
      safe_torque_removal_input = 0;
      wt(16'h00C8);
      xfer(1, `PTC_IDX_SETPOINT, 0, `PTC_AB_NONE);
      wt(16'h0000);
      brk = 1;
      @(negedge clk);
      chk32({31'b0, brk_o}, 32'h0000_0000);
      rdv(`PTC_IDX_TQ_MEAS, '1, 32'hFFFF_FFFB);
      rdv(`PTC_IDX_CUR_MEAS, '1, 32'h0000_0007);
      rdv(`PTC_IDX_VBUS, '1, 32'h0000_0190);
      note("halt and stops");
      xfer(1, `PTC_IDX_SETPOINT, 200, `PTC_AB_NONE);
      wt(16'h00C8);
      xfer(1, `PTC_IDX_CMD, 32'h0000_0007, `PTC_AB_NONE);
      wt(16'h0000);
      rdv(`PTC_IDX_STATE, 32'h0000_0404, 32'h0000_0000);
      // Slope of one clock rate per second gives one unit a cycle
      xfer(1, `PTC_IDX_RAMP_SHAPE, 0, `PTC_AB_NONE);
      xfer(1, `PTC_IDX_RAMP_RATE, 32'h0262_5A00, `PTC_AB_NONE);
      xfer(1, `PTC_IDX_CMD, 32'h0000_000F, `PTC_AB_NONE);
      xfer(1, `PTC_IDX_SETPOINT, 20, `PTC_AB_NONE);
      rdv(`PTC_IDX_TQ_OUT, '1, 32'h0000_0003);
      wt(16'h0014);
      flt = 1;
      @(negedge clk);
      flt = 0;
      wt(16'h0000);
      rdv(`PTC_IDX_FAULT, '1, 32'h0000_FF00);
      rdv(`PTC_IDX_STATE, 32'h0000_0008, 32'h0000_0008);
      note("disable ramp fault");
      complete_run;
   end
endmodule // profile_torque_mode_control_tb
